/* rac_bus_model.sv */
`timescale 1ns/100ps

//==============================================================
// bus voltage sensing and speed feedback model
//==============================================================
module rac_bus_model (
   input  wire logic        mclk,
   input  wire logic        tick_req,
   input  wire logic [9:0]  volts_req,
   input  wire logic [13:0] rot_req,
   output logic             ctrl_tick,
   output logic      [9:0]  bus_voltage,
   output logic      [13:0] rot_speed
);
   logic        tick_hold;
   logic [9:0]  volts_hold;
   logic [13:0] rot_hold;

   // capture requests on the rising edge, so no race with the bench
   always @(posedge mclk) begin
      tick_hold <= tick_req;
      volts_hold <= volts_req;
      rot_hold <= rot_req;
   end

   // launch on the falling edge, well clear of the sampling edge
   always @(negedge mclk) begin
      ctrl_tick <= tick_hold;
      bus_voltage <= volts_hold;
      rot_speed <= rot_hold;
   end
endmodule // rac_bus_model

/* rac_gain_scale.sv */
//==============================================================
// shared constants
//==============================================================
package rac_pkg;
   localparam int unsigned RAC_SPD_W = 14;   // r/min, holds 9999
   localparam int unsigned RAC_VLT_W = 10;   // volts
   localparam int unsigned RAC_GAIN_W = 8;   // percent
   // mode select values
   localparam logic [1:0] RAC_MODE_OFF    = 2'h0;
   localparam logic [1:0] RAC_MODE_ALWAYS = 2'h1;
   localparam logic [1:0] RAC_MODE_CONST  = 2'h2;
   // accel/decel state encoding on the input port
   localparam logic [1:0] RAC_RUN_CONST = 2'h0;
   localparam logic [1:0] RAC_RUN_ACCEL = 2'h1;
   localparam logic [1:0] RAC_RUN_DECEL = 2'h2;
   // configuration select codes
   localparam logic [2:0] RAC_CFG_MODE  = 3'h0;
   localparam logic [2:0] RAC_CFG_LEVEL = 3'h1;
   localparam logic [2:0] RAC_CFG_LIMIT = 3'h2;
   localparam logic [2:0] RAC_CFG_VGAIN = 3'h3;
   localparam logic [2:0] RAC_CFG_SGAIN = 3'h4;
   // reset values and ranges
   localparam logic [13:0] RAC_LEVEL_RST  = 14'h0190;  // 400 V
   localparam logic [13:0] RAC_LEVEL_MIN  = 14'h012c;  // 300 V
   localparam logic [13:0] RAC_LEVEL_MAX  = 14'h0320;  // 800 V
   localparam logic [13:0] RAC_LIMIT_RST  = 14'h00b4;  // 180 r/min
   localparam logic [13:0] RAC_LIMIT_MAX  = 14'h0384;  // 900 r/min
   localparam logic [13:0] RAC_LIMIT_OFF  = 14'h270f;  // 9999
   localparam logic [13:0] RAC_GAIN_RST   = 14'h0064;  // 100 %
   localparam logic [13:0] RAC_GAIN_MAX   = 14'h00c8;  // 200 %
   localparam logic [13:0] RAC_LOW_SPEED  = 14'h00e1;  // 225 r/min
   localparam logic [13:0] RAC_SPD_SAT    = 14'h3fff;
   localparam logic [21:0] RAC_PCT_DIV    = 22'h000064;  // 100 %
endpackage : rac_pkg

`timescale 1ns/100ps

//==============================================================
// percent gain scaler, saturating
//==============================================================
module rac_gain_scale
   import rac_pkg::*;
(
   input  wire logic [13:0] value_in,
   input  wire logic [7:0]  gain_pct,
   output logic      [13:0] value_out
);
   logic [21:0] product;
   logic [21:0] quotient;

   // divide after multiply keeps small excess values alive
   always_comb begin
      product  = 22'(value_in) * 22'(gain_pct);
      quotient = product / RAC_PCT_DIV;
      value_out = (quotient > 22'(RAC_SPD_SAT)) ? RAC_SPD_SAT : quotient[13:0];
   end
endmodule // rac_gain_scale

/* rac_regen_ctrl.sv */
//==============================================================
// regeneration avoidance speed compensation
//==============================================================
`timescale 1ns/100ps

module rac_regen_ctrl
   import rac_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        ctrl_tick,
   input  wire logic [9:0]  bus_voltage,
   input  wire logic [13:0] speed_cmd,
   input  wire logic [13:0] rot_speed,
   input  wire logic [1:0]  run_state,
   input  wire logic [13:0] max_speed_setting,
   input  wire logic [7:0]  extended_display_select,
   input  wire logic        cfg_write,
   input  wire logic [2:0]  cfg_sel,
   input  wire logic [13:0] cfg_data,
   output logic      [13:0] speed_out_reg,
   output logic             avoid_active_reg,
   output logic             stall_indication_signal,
   output logic             ov_stall_display_reg,
   output logic             stall_prevent_reg,
   output logic      [1:0]  regen_mode_select,
   output logic      [13:0] regen_voltage_level
);
   //===========================================================
   // settings
   //===========================================================
   logic [1:0]  mode_next;
   logic [13:0] level_reg, level_next, limit_reg, limit_next;
   logic [7:0]  vgain_reg, vgain_next, sgain_reg, sgain_next;
   logic        cfg_ok;

   // write gate: refused writes leave settings untouched
   always_comb begin
      cfg_ok     = cfg_write && (extended_display_select == 8'h00);
      mode_next  = regen_mode_select;
      level_next = level_reg;
      limit_next = limit_reg;
      vgain_next = vgain_reg;
      sgain_next = sgain_reg;
      if (cfg_ok) begin
         case (cfg_sel)
            RAC_CFG_MODE: if (cfg_data <= 14'(RAC_MODE_CONST)) mode_next = cfg_data[1:0];
            RAC_CFG_LEVEL:
               if (cfg_data >= RAC_LEVEL_MIN && cfg_data <= RAC_LEVEL_MAX) level_next = cfg_data;
            RAC_CFG_LIMIT:
               if (cfg_data <= RAC_LIMIT_MAX || cfg_data == RAC_LIMIT_OFF) limit_next = cfg_data;
            RAC_CFG_VGAIN: if (cfg_data <= RAC_GAIN_MAX) vgain_next = cfg_data[7:0];
            RAC_CFG_SGAIN: if (cfg_data <= RAC_GAIN_MAX) sgain_next = cfg_data[7:0];
            default: mode_next = regen_mode_select;
         endcase
      end
   end

   // settings registers
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         regen_mode_select <= RAC_MODE_OFF;
         level_reg         <= RAC_LEVEL_RST;
         limit_reg         <= RAC_LIMIT_RST;
         vgain_reg         <= RAC_GAIN_RST[7:0];
         sgain_reg         <= RAC_GAIN_RST[7:0];
         regen_voltage_level <= RAC_LEVEL_RST;
      end else begin
         regen_mode_select <= mode_next;
         level_reg         <= level_next;
         limit_reg         <= limit_next;
         vgain_reg         <= vgain_next;
         sgain_reg         <= sgain_next;
         regen_voltage_level <= level_next;
      end
   end

   //===========================================================
   // compensation step
   //===========================================================
   logic [13:0] excess, scaled_v, step;
   logic        mode_ok, above_low, over_level, trigger;

   always_comb begin
      mode_ok    = (regen_mode_select == RAC_MODE_ALWAYS) ||
                   ((regen_mode_select == RAC_MODE_CONST) && (run_state == RAC_RUN_CONST));
      above_low  = speed_cmd > RAC_LOW_SPEED;
      over_level = 14'(bus_voltage) >= level_reg;
      trigger    = mode_ok && above_low && over_level;
      excess     = over_level ? (14'(bus_voltage) - level_reg) : 14'h0000;
   end

   // voltage gain on the bus excess
   rac_gain_scale u_vgain (
      .value_in  (excess),
      .gain_pct  (vgain_reg),
      .value_out (scaled_v)
   );

   // speed gain on the correction step
   rac_gain_scale u_sgain (
      .value_in  (scaled_v),
      .gain_pct  (sgain_reg),
      .value_out (step)
   );

   //===========================================================
   // compensation state and output
   //===========================================================
   logic [13:0] comp_reg, comp_next, base_reg, base_next, speed_next;
   logic        active_next, hold_reg, hold_next, limit_on;
   logic [14:0] comp_sum, raised, limit_spd, capped;

   always_comb begin
      limit_on    = limit_reg != RAC_LIMIT_OFF;
      comp_next   = comp_reg;
      base_next   = base_reg;
      hold_next   = hold_reg;
      active_next = avoid_active_reg;
      speed_next  = speed_out_reg;
      comp_sum    = 15'(comp_reg) + 15'(step) + 15'h0001;
      if (ctrl_tick) begin
         if (!mode_ok || !above_low) begin
            // lockout drops any correction at once
            comp_next = 14'h0000;
         end else if (over_level) begin
            // integrate in proportion to the excess
            if (!avoid_active_reg) begin
               base_next = speed_cmd;
            end
            comp_next = comp_sum[14] ? RAC_SPD_SAT : comp_sum[13:0];
         end else if (comp_reg != 14'h0000) begin
            // slow bleed avoids a speed step when the bus recovers
            comp_next = comp_reg - 14'h0001;
         end
         active_next = trigger || (comp_next != 14'h0000);
      end
      raised    = 15'(speed_cmd) + 15'(comp_next);
      limit_spd = 15'(base_next) + 15'(limit_reg);
      // cap at start speed plus limit unless unlimited
      capped    = (limit_on && raised > limit_spd) ? limit_spd : raised;
      if (ctrl_tick) begin
         // decel hold released at half of start speed
         if (!active_next || run_state != RAC_RUN_DECEL) begin
            hold_next = 1'b0;
         end else if (rot_speed <= (base_next >> 1)) begin
            hold_next = 1'b0;
         end else if (limit_on && raised > limit_spd) begin
            hold_next = 1'b1;
         end
         if (hold_next) begin
            capped = limit_spd;
         end
         // clamp to maximum speed while active, update on tick only
         if (active_next) begin
            speed_next = (capped > 15'(max_speed_setting)) ? max_speed_setting : capped[13:0];
         end else begin
            speed_next = speed_cmd;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         comp_reg                <= 14'h0000;
         base_reg                <= 14'h0000;
         hold_reg                <= 1'b0;
         speed_out_reg           <= 14'h0000;
         avoid_active_reg        <= 1'b0;
         stall_indication_signal <= 1'b0;
         ov_stall_display_reg    <= 1'b0;
         stall_prevent_reg       <= 1'b0;
      end else begin
         comp_reg                <= comp_next;
         base_reg                <= base_next;
         hold_reg                <= hold_next;
         speed_out_reg           <= speed_next;
         avoid_active_reg        <= active_next;
         stall_indication_signal <= active_next;
         ov_stall_display_reg    <= active_next;
         stall_prevent_reg       <= active_next;
      end
   end

   //===========================================================
   // checks
   //===========================================================
   property p_mode_off;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && regen_mode_select == RAC_MODE_OFF) |=> !avoid_active_reg;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("active in mode off");

   property p_const_only;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && regen_mode_select == RAC_MODE_CONST && run_state != RAC_RUN_CONST)
         |=> (comp_reg == 14'h0000);
   endproperty
   a_const_only: assert property (p_const_only) else $error("mode 2 outside const");

   property p_trigger;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && trigger) |=> (avoid_active_reg && stall_indication_signal);
   endproperty
   a_trigger: assert property (p_trigger) else $error("level reached, no action");

   property p_cap;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && active_next && limit_on && run_state != RAC_RUN_DECEL)
         |=> (15'(speed_out_reg) <= $past(limit_spd));
   endproperty
   a_cap: assert property (p_cap) else $error("compensation over limit");

   property p_unlimited;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && active_next && !limit_on && raised <= 15'(max_speed_setting))
         |=> (15'(speed_out_reg) == $past(raised));
   endproperty
   a_unlimited: assert property (p_unlimited) else $error("9999 still limited");

   property p_hold;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && hold_next && limit_spd <= 15'(max_speed_setting))
         |=> (15'(speed_out_reg) == $past(limit_spd));
   endproperty
   a_hold: assert property (p_hold) else $error("decel hold lost");

   property p_max;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && active_next) |=> (speed_out_reg <= $past(max_speed_setting));
   endproperty
   a_max: assert property (p_max) else $error("over maximum speed");

   property p_vgain;
      @(posedge mclk) disable iff (!reset_n)
      (vgain_reg == 8'h00) |-> (step == 14'h0000);
   endproperty
   a_vgain: assert property (p_vgain) else $error("zero voltage gain moved");

   property p_step;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && trigger && !comp_sum[14])
         |=> (comp_reg == $past(comp_reg) + $past(step) + 14'h0001);
   endproperty
   a_step: assert property (p_step) else $error("step not gain scaled");

   property p_low;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_tick && speed_cmd <= RAC_LOW_SPEED) |=> (!avoid_active_reg && comp_reg == 14'h0000);
   endproperty
   a_low: assert property (p_low) else $error("active at low speed");

   property p_indicate;
      @(posedge mclk) disable iff (!reset_n)
      avoid_active_reg |-> (stall_indication_signal && ov_stall_display_reg);
   endproperty
   a_indicate: assert property (p_indicate) else $error("no overload indication");

   property p_stall_prev;
      @(posedge mclk) disable iff (!reset_n)
      avoid_active_reg |-> stall_prevent_reg;
   endproperty
   a_stall_prev: assert property (p_stall_prev) else $error("stall prevention idle");

   property p_wr_gate;
      @(posedge mclk) disable iff (!reset_n)
      (extended_display_select != 8'h00) |=> ($stable(level_reg) && $stable(limit_reg));
   endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("setting changed while locked");

   property p_tick;
      @(posedge mclk) disable iff (!reset_n)
      !ctrl_tick |=> ($stable(speed_out_reg) && $stable(comp_reg));
   endproperty
   a_tick: assert property (p_tick) else $error("update without tick");
endmodule // rac_regen_ctrl

/* tb.sv */
`timescale 1ns/100ps

//==============================================================
// testbench top
//==============================================================
module tb
   import rac_pkg::*;
;
   logic        mclk, reset_n, tick_req, cfg_write, ctrl_tick;
   logic [9:0]  volts_req, bus_voltage;
   logic [13:0] rot_req, rot_speed, speed_cmd, max_speed_setting, cfg_data;
   logic [1:0]  run_state, regen_mode_select;
   logic [7:0]  extended_display_select;
   logic [2:0]  cfg_sel;
   logic [13:0] speed_out_reg, regen_voltage_level;
   logic        avoid_active_reg, stall_indication_signal;
   logic        ov_stall_display_reg, stall_prevent_reg;
   int          n_errors, samples_checked, cycles;

   rac_bus_model u_model (.mclk(mclk), .tick_req(tick_req), .volts_req(volts_req),
      .rot_req(rot_req), .ctrl_tick(ctrl_tick), .bus_voltage(bus_voltage),
      .rot_speed(rot_speed));

   rac_regen_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .ctrl_tick(ctrl_tick),
      .bus_voltage(bus_voltage), .speed_cmd(speed_cmd), .rot_speed(rot_speed),
      .run_state(run_state), .max_speed_setting(max_speed_setting),
      .extended_display_select(extended_display_select), .cfg_write(cfg_write),
      .cfg_sel(cfg_sel), .cfg_data(cfg_data), .speed_out_reg(speed_out_reg),
      .avoid_active_reg(avoid_active_reg),
      .stall_indication_signal(stall_indication_signal),
      .ov_stall_display_reg(ov_stall_display_reg),
      .stall_prevent_reg(stall_prevent_reg),
      .regen_mode_select(regen_mode_select),
      .regen_voltage_level(regen_voltage_level));

   //==============================================================
   // clock and hang guard
   //==============================================================
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         complete_run();
      end
   end

   //==============================================================
   // access and compare tasks
   //==============================================================
   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // corrected speed and all four acting flags together
   task automatic chk_out(input logic [13:0] s, input logic a);
      chk("speed_out", s, speed_out_reg);
      chk("active", {13'h0, a}, {13'h0, avoid_active_reg});
      chk("overload", {13'h0, a}, {13'h0, stall_indication_signal});
      chk("ov_display", {13'h0, a}, {13'h0, ov_stall_display_reg});
      chk("stall_prevent", {13'h0, a}, {13'h0, stall_prevent_reg});
   endtask

   // one write strobe; returns after the readback edge has passed
   task automatic cfg(input logic [2:0] s, input logic [13:0] d);
      @(negedge mclk);
      cfg_write = 1'b1;
      cfg_sel = s;
      cfg_data = d;
      @(negedge mclk);
      cfg_write = 1'b0;
      @(negedge mclk);
   endtask

   // one control tick through the model; returns once the answer stands
   task automatic tk(input logic [9:0] v, input logic [13:0] s, input logic [1:0] rs,
                     input logic [13:0] r);
      @(negedge mclk);
      volts_req = v;
      rot_req = r;
      speed_cmd = s;
      run_state = rs;
      tick_req = 1'b1;
      @(negedge mclk);
      tick_req = 1'b0;
      repeat (3) @(negedge mclk);
   endtask

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   //==============================================================
   // main sequence
   //==============================================================
   initial begin
      reset_n = 1'b0;
      tick_req = 1'b0;
      // idle bus at a normal level, below the default trigger
      volts_req = 10'h137;
      rot_req = 14'h03e8;
      speed_cmd = 14'h03e8;
      run_state = RAC_RUN_CONST;
      max_speed_setting = 14'h0bb8;
      extended_display_select = 8'h01;
      cfg_write = 1'b0;
      cfg_sel = 3'h0;
      cfg_data = 14'h0000;
      repeat (10) @(negedge mclk);
      reset_n = 1'b1;
      chk("mode", 14'h0000, {12'h0, regen_mode_select});
      chk("level", RAC_LEVEL_RST, regen_voltage_level);
      chk_out(14'h0000, 1'b0);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03e8, 1'b0);
      cfg(RAC_CFG_MODE, 14'h0001);
      chk("mode", 14'h0000, {12'h0, regen_mode_select});
      extended_display_select = 8'h00;
      cfg(RAC_CFG_LEVEL, 14'h0384);
      chk("level", RAC_LEVEL_RST, regen_voltage_level);
      cfg(RAC_CFG_MODE, 14'h0003);
      chk("mode", 14'h0000, {12'h0, regen_mode_select});
      cfg(RAC_CFG_MODE, 14'h0001);
      chk("mode", 14'h0001, {12'h0, regen_mode_select});
      tk(10'h190, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03e9, 1'b1);
      tk(10'h18f, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03e8, 1'b0);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h044d, 1'b1);
      tk(10'h1f4, 14'h03e8, RAC_RUN_ACCEL, 14'h03e8);
      chk_out(14'h049c, 1'b1);
      tk(10'h1f4, 14'h03e8, RAC_RUN_DECEL, 14'h03e8);
      chk_out(14'h049c, 1'b1);
      tk(10'h12c, 14'h0320, RAC_RUN_DECEL, 14'h03e8);
      chk_out(14'h049c, 1'b1);
      tk(10'h12c, 14'h0320, RAC_RUN_DECEL, 14'h01f4);
      chk_out(14'h044d, 1'b1);
      tk(10'h1f4, 14'h00e1, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h00e1, 1'b0);
      cfg(RAC_CFG_LIMIT, RAC_LIMIT_OFF);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h04b2, 1'b1);
      max_speed_setting = 14'h047e;
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h047e, 1'b1);
      tk(10'h1f4, 14'h00e1, RAC_RUN_CONST, 14'h03e8);
      max_speed_setting = 14'h0bb8;
      cfg(RAC_CFG_VGAIN, 14'h00c8);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h04b1, 1'b1);
      tk(10'h1f4, 14'h00e1, RAC_RUN_CONST, 14'h03e8);
      cfg(RAC_CFG_SGAIN, 14'h0000);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03e9, 1'b1);
      tk(10'h1f4, 14'h00e1, RAC_RUN_CONST, 14'h03e8);
      cfg(RAC_CFG_MODE, 14'h0002);
      tk(10'h1f4, 14'h03e8, RAC_RUN_ACCEL, 14'h03e8);
      chk_out(14'h03e8, 1'b0);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03e9, 1'b1);
      cfg(RAC_CFG_LEVEL, 14'h012c);
      chk("level", 14'h012c, regen_voltage_level);
      tk(10'h12c, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03ea, 1'b1);
      // zero voltage gain must kill the step even with speed gain back at 100
      cfg(RAC_CFG_VGAIN, 14'h0000);
      cfg(RAC_CFG_SGAIN, 14'h0064);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03eb, 1'b1);
      // small in-range limit caps at start speed plus one
      cfg(RAC_CFG_LIMIT, 14'h0001);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03e9, 1'b1);
      // out-of-range limit is refused, the old cap stays
      cfg(RAC_CFG_LIMIT, 14'h0385);
      tk(10'h1f4, 14'h03e8, RAC_RUN_CONST, 14'h03e8);
      chk_out(14'h03e9, 1'b1);
      complete_run();
   end
endmodule // tb
